// ---- rtl/ram_block.sv ----
// Notes on behaviour
// - simple dual-port: write on A, read on B
// - simple dual-port runs read/write or input/output clocking
// - small widths pair within groups: plain with plain, parity with parity
// - large widths pair alike within plain/parity groups
// - separate read and write enables; fabric idles read
// - same-address read in simple mode: undefined or old
// - lite variant: write enable only, limited collision choice
// - lite mixed widths come from combined memories
// - output register adds exactly one cycle
// - true dual-port: any read/write mix per port
// - true dual-port runs independent or input/output clocking
// - true dual-port width capped at 16/18 or 32/36
// - small true dual-port widths pair within groups
// - large true dual-port widths pair within groups
// - same-port collision gives new or old data
// - every word reachable from either port
// - shift chain sized width times length times taps
// - rom loaded by software, address sampled on edge
// - output registers clear asynchronously
// - fifo single or split clocking; lite same width
// - new-data mode shows written word same edge
// - split clocks make cross-port collision undefined
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`default_nettype none
module ram_block (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic out_clr_i,
    input wire logic ce_a_i,
    input wire logic ce_b_i,
    input wire logic ce_out_i,
    input wire logic [9:0] addr_a_i,
    input wire logic [35:0] wdata_a_i,
    input wire logic we_a_i,
    input wire logic re_a_i,
    output logic [35:0] rdata_a_o,
    input wire logic [9:0] addr_b_i,
    input wire logic [35:0] wdata_b_i,
    input wire logic we_b_i,
    input wire logic re_b_i,
    output logic [35:0] rdata_b_o,
    output logic [35:0] shift_out_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    // lane helpers for mixed widths over one 36-bit word
    function automatic logic [35:0] lane_get(input logic [35:0] w, input ram_pkg::width_t wd,
                                             input logic [1:0] ln);
        logic [35:0] r;
        r = '0;
        unique case (wd)
            ram_pkg::W8: r[7:0] = w[{ln, 3'b000} +: 8];
            ram_pkg::W16: r[15:0] = w[{ln[0], 4'b0000} +: 16];
            ram_pkg::W32: r[31:0] = w[31:0];
            ram_pkg::W9: r[8:0] = w[9 * ln +: 9];
            ram_pkg::W18: r[17:0] = w[18 * ln[0] +: 18];
            default: r = w;
        endcase
        return r;
    endfunction

    function automatic logic [35:0] lane_put(input logic [35:0] w, input logic [35:0] d,
                                             input ram_pkg::width_t wd, input logic [1:0] ln);
        logic [35:0] r;
        r = w;
        unique case (wd)
            ram_pkg::W8: r[{ln, 3'b000} +: 8] = d[7:0];
            ram_pkg::W16: r[{ln[0], 4'b0000} +: 16] = d[15:0];
            ram_pkg::W32: r[31:0] = d[31:0];
            ram_pkg::W9: r[9 * ln +: 9] = d[8:0];
            ram_pkg::W18: r[18 * ln[0] +: 18] = d[17:0];
            default: r = d;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] word_of(input logic [9:0] a, input ram_pkg::width_t wd);
        if (wd == ram_pkg::W8 || wd == ram_pkg::W9) begin
            return a[9:2];
        end else if (wd == ram_pkg::W16 || wd == ram_pkg::W18) begin
            return a[8:1];
        end
        return a[7:0];
    endfunction

    function automatic logic [1:0] lane_of(input logic [9:0] a, input ram_pkg::width_t wd);
        if (wd == ram_pkg::W8 || wd == ram_pkg::W9) begin
            return a[1:0];
        end else if (wd == ram_pkg::W16 || wd == ram_pkg::W18) begin
            return {1'b0, a[0]};
        end
        return 2'b00;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8 * i +: 8] = n[8 * i +: 8];
            end
        end
        return r;
    endfunction

    logic [35:0] mem [ram_pkg::DEPTH];
    ram_pkg::ctrl_t ctrl_reg;
    ram_pkg::shift_t shift_reg;
    logic [7:0] maddr_reg;
    logic [3:0] mpar_reg;
    logic [7:0] sh_ptr_reg, f_wptr_reg, f_rptr_reg;
    logic [8:0] f_cnt_reg;
    logic aw_ok_reg, w_ok_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic cfg_err, ok, two_clk, in_b, io_clk, single_clk, tdp, sdp, fifo, shift, rom;
    logic grp_a, grp_b, wr_a, wr_b, do_wr, known_wr, known_rd;
    logic [7:0] wa_word, wb_word, ra_word, rb_word, tap_idx;
    logic [1:0] la, lb;
    logic [15:0] sh_len, sh_km, sh_pp;
    logic [35:0] wdat_a, old_a, old_b;
    logic [1:0] rd, oce;
    logic [1:0][35:0] raw, pipe, q;
    ram_pkg::status_t status;
    logic [31:0] rd_mux;

    // mode and clock arrangement decode
    always_comb begin
        sdp = ctrl_reg.mode == ram_pkg::MODE_SDP;
        tdp = ctrl_reg.mode == ram_pkg::MODE_TDP;
        shift = ctrl_reg.mode == ram_pkg::MODE_SHIFT;
        rom = ctrl_reg.mode == ram_pkg::MODE_ROM;
        fifo = ctrl_reg.mode == ram_pkg::MODE_FIFO;
        single_clk = ctrl_reg.clk_mode == ram_pkg::CLK_SINGLE;
        io_clk = ctrl_reg.clk_mode == ram_pkg::CLK_IO;
        two_clk = !single_clk && !io_clk;
        grp_a = ctrl_reg.wid_a >= ram_pkg::W9;
        grp_b = ctrl_reg.wid_b >= ram_pkg::W9;
        sh_len = 16'(shift_reg.tap_len) * 16'(shift_reg.taps);
        sh_km = 16'(shift_reg.tap_sel) * 16'(shift_reg.tap_len);
    end

    // illegal configurations stop all fabric traffic
    always_comb begin
        cfg_err = ctrl_reg.mode > ram_pkg::MODE_FIFO;
        cfg_err = cfg_err || ctrl_reg.wid_a > ram_pkg::W36 || ctrl_reg.wid_b > ram_pkg::W36;
        cfg_err = cfg_err || ((sdp || tdp) && grp_a != grp_b);
        cfg_err = cfg_err || (tdp && ctrl_reg.small_blk &&
                  (ctrl_reg.wid_a inside {ram_pkg::W32, ram_pkg::W36} ||
                   ctrl_reg.wid_b inside {ram_pkg::W32, ram_pkg::W36}));
        cfg_err = cfg_err || (tdp && ctrl_reg.lite);
        cfg_err = cfg_err || (fifo && ctrl_reg.lite && ctrl_reg.wid_a != ctrl_reg.wid_b);
        cfg_err = cfg_err || (sdp && ctrl_reg.clk_mode == ram_pkg::CLK_INDEP);
        cfg_err = cfg_err || (tdp && ctrl_reg.clk_mode == ram_pkg::CLK_RW);
        cfg_err = cfg_err || (rom && ctrl_reg.clk_mode == ram_pkg::CLK_RW);
        cfg_err = cfg_err || (fifo && (io_clk || ctrl_reg.clk_mode == ram_pkg::CLK_INDEP));
        cfg_err = cfg_err || (shift && (sh_len == 16'h0000 || sh_len > 16'h0100 ||
                  shift_reg.tap_sel == 8'h00 || shift_reg.tap_sel > shift_reg.taps));
        ok = !cfg_err;
    end

    // port clock enables per clocking arrangement
    always_comb begin
        in_b = two_clk ? ce_b_i : ce_a_i;
        oce[0] = io_clk ? ce_out_i : ce_a_i;
        oce[1] = io_clk ? ce_out_i : (single_clk ? ce_a_i : ce_b_i);
    end

    // word and lane selection for each port
    always_comb begin
        la = lane_of(addr_a_i, ctrl_reg.wid_a);
        lb = lane_of(addr_b_i, ctrl_reg.wid_b);
        ra_word = word_of(addr_a_i, ctrl_reg.wid_a);
        wb_word = word_of(addr_b_i, ctrl_reg.wid_b);
        sh_pp = {8'h00, sh_ptr_reg};
        tap_idx = (sh_pp >= sh_km) ? sh_km[7:0] : 8'h00;
        tap_idx = (sh_pp >= sh_km) ? 8'(sh_pp - sh_km) : 8'(sh_pp + sh_len - sh_km);
        wa_word = shift ? sh_ptr_reg : (fifo ? f_wptr_reg : ra_word);
        rb_word = shift ? tap_idx : (fifo ? f_rptr_reg : wb_word);
        wdat_a = (fifo || shift) ? wdata_a_i : lane_put(mem[wa_word], wdata_a_i,
                                                         ctrl_reg.wid_a, la);
    end

    // access qualification
    always_comb begin
        wr_a = ce_a_i && we_a_i && ok && !rom && !(fifo && f_cnt_reg[8]);
        wr_b = in_b && we_b_i && ok && tdp;
        rd[0] = ce_a_i && (re_a_i || ctrl_reg.lite) && ok && (tdp || rom);
        rd[1] = shift ? wr_a : (in_b && (re_b_i || ctrl_reg.lite) && ok &&
                (sdp || tdp || (fifo && f_cnt_reg != 9'h000)));
    end

    // read results including collision handling
    always_comb begin
        old_a = lane_get(mem[ra_word], ctrl_reg.wid_a, la);
        old_b = lane_get(mem[rb_word], ctrl_reg.wid_b, lb);
        raw[0] = old_a;
        raw[1] = old_b;
        if (fifo || shift) begin
            raw[1] = mem[rb_word];
        end else if (wr_a && wa_word == rb_word) begin
            raw[1] = (two_clk || !ctrl_reg.mixed_old) ? ram_pkg::DC_FILL : old_b;
        end else if (wr_b && wb_word == rb_word && ctrl_reg.same_new) begin
            raw[1] = lane_get(lane_put(mem[wb_word], wdata_b_i, ctrl_reg.wid_b, lb),
                              ctrl_reg.wid_b, lb);
        end
        if (wr_b && wb_word == ra_word) begin
            raw[0] = (two_clk || !ctrl_reg.mixed_old) ? ram_pkg::DC_FILL : old_a;
        end else if (wr_a && ctrl_reg.same_new) begin
            raw[0] = lane_get(wdat_a, ctrl_reg.wid_a, la);
        end
    end

    // array writes; the bus load wins over fabric in its cycle
    always_ff @(posedge clk_i) begin
        if (do_wr && aw_addr_reg == ram_pkg::OFF_MDATA) begin
            mem[maddr_reg] <= {mpar_reg, strb_merge(mem[maddr_reg][31:0], w_data_reg,
                                                     w_strb_reg)};
        end else begin
            if (wr_a) begin
                mem[wa_word] <= wdat_a;
            end
            if (wr_b && !(wr_a && wa_word == wb_word)) begin
                mem[wb_word] <= lane_put(mem[wb_word], wdata_b_i, ctrl_reg.wid_b, lb);
            end
        end
    end

    // output stage per port, optional extra register
    for (genvar p = 0; p < 2; p++) begin : g_out
        always_ff @(posedge clk_i or negedge reset_n_i or posedge out_clr_i) begin
            if (!reset_n_i || out_clr_i) begin
                pipe[p] <= '0;
                q[p] <= '0;
            end else begin
                if (rd[p]) begin
                    pipe[p] <= raw[p];
                end
                if (!ctrl_reg.out_reg && rd[p]) begin
                    q[p] <= raw[p];
                end else if (ctrl_reg.out_reg && oce[p]) begin
                    q[p] <= pipe[p];
                end
            end
        end
    end
    assign rdata_a_o = q[0];
    assign rdata_b_o = q[1];

    // shift pointer and cascade output
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sh_ptr_reg <= '0;
            shift_out_o <= '0;
        end else if (do_wr && aw_addr_reg == ram_pkg::OFF_CTRL) begin
            sh_ptr_reg <= '0;
        end else if (shift && wr_a) begin
            shift_out_o <= mem[sh_ptr_reg];
            sh_ptr_reg <= (9'({1'b0, sh_ptr_reg}) + 9'h001 == sh_len[8:0]) ? 8'h00 :
                          sh_ptr_reg + 8'h01;
        end
    end

    // fifo pointers, cleared by any control write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            f_wptr_reg <= '0;
            f_rptr_reg <= '0;
            f_cnt_reg <= '0;
        end else if (do_wr && aw_addr_reg == ram_pkg::OFF_CTRL) begin
            f_wptr_reg <= '0;
            f_rptr_reg <= '0;
            f_cnt_reg <= '0;
        end else if (fifo) begin
            f_wptr_reg <= f_wptr_reg + 8'(wr_a);
            f_rptr_reg <= f_rptr_reg + 8'(rd[1]);
            f_cnt_reg <= f_cnt_reg + 9'(wr_a) - 9'(rd[1]);
        end
    end

    // bus write channel capture and response
    always_comb begin
        do_wr = aw_ok_reg && w_ok_reg && !s_axi_bvalid_o;
        known_wr = aw_addr_reg inside {ram_pkg::OFF_CTRL, ram_pkg::OFF_MADDR,
                   ram_pkg::OFF_MDATA, ram_pkg::OFF_MPAR, ram_pkg::OFF_SHIFT,
                   ram_pkg::OFF_STATUS};
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_ok_reg <= 1'b0;
            w_ok_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= ram_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_ok_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_ok_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_wr) begin
                aw_ok_reg <= 1'b0;
                w_ok_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= known_wr ? ram_pkg::RESP_OKAY : ram_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // software registers; status is read only
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= ram_pkg::ctrl_t'(ram_pkg::CTRL_RST);
            shift_reg <= ram_pkg::shift_t'(ram_pkg::SHIFT_RST);
            maddr_reg <= '0;
            mpar_reg <= '0;
        end else if (do_wr) begin
            unique case (aw_addr_reg)
                ram_pkg::OFF_CTRL: ctrl_reg <= ram_pkg::ctrl_t'(16'(strb_merge(
                    {16'h0000, ctrl_reg}, w_data_reg, w_strb_reg)));
                ram_pkg::OFF_SHIFT: shift_reg <= ram_pkg::shift_t'(24'(strb_merge(
                    {8'h00, shift_reg}, w_data_reg, w_strb_reg)));
                ram_pkg::OFF_MADDR: maddr_reg <= w_strb_reg[0] ? w_data_reg[7:0] : maddr_reg;
                ram_pkg::OFF_MPAR: mpar_reg <= w_strb_reg[0] ? w_data_reg[3:0] : mpar_reg;
                default: ;
            endcase
        end
    end

    // read channel
    always_comb begin
        status = '0;
        status.fifo_cnt = f_cnt_reg;
        status.full = f_cnt_reg[8];
        status.empty = f_cnt_reg == 9'h000;
        status.cfg_err = cfg_err;
        known_rd = 1'b1;
        unique case (s_axi_araddr_i)
            ram_pkg::OFF_CTRL: rd_mux = {16'h0000, ctrl_reg};
            ram_pkg::OFF_STATUS: rd_mux = status;
            ram_pkg::OFF_MADDR: rd_mux = {24'h000000, maddr_reg};
            ram_pkg::OFF_MDATA: rd_mux = mem[maddr_reg][31:0];
            ram_pkg::OFF_MPAR: rd_mux = {28'h0000000, mem[maddr_reg][35:32]};
            ram_pkg::OFF_SHIFT: rd_mux = {8'h00, shift_reg};
            default: begin
                rd_mux = 32'h00000000;
                known_rd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= ram_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= rd_mux;
            s_axi_rresp_o <= known_rd ? ram_pkg::RESP_OKAY : ram_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    property p_hold;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (!rd[1] && !ctrl_reg.out_reg) |=> $stable(rdata_b_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");

    property p_outreg;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (rd[1] && ctrl_reg.out_reg) ##1 (oce[1] && ctrl_reg.out_reg) |=>
        rdata_b_o == $past(raw[1], 2);
    endproperty
    a_outreg: assert property (p_outreg) else $error("registered read not one cycle late");

    property p_rdw_dc;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (sdp && rd[1] && wr_a && wa_word == rb_word && !ctrl_reg.mixed_old &&
         !ctrl_reg.out_reg) |=> rdata_b_o == ram_pkg::DC_FILL;
    endproperty
    a_rdw_dc: assert property (p_rdw_dc) else $error("collision not shown undefined");

    property p_rdw_old;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (sdp && !two_clk && rd[1] && wr_a && wa_word == rb_word && ctrl_reg.mixed_old &&
         !ctrl_reg.out_reg) |=> rdata_b_o == $past(old_b);
    endproperty
    a_rdw_old: assert property (p_rdw_old) else $error("collision lost old data");

    property p_two_clk;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (two_clk && (sdp || tdp) && rd[1] && wr_a && wa_word == rb_word &&
         !ctrl_reg.out_reg) |=> rdata_b_o == ram_pkg::DC_FILL;
    endproperty
    a_two_clk: assert property (p_two_clk) else $error("split clock collision defined");

    property p_new;
        @(posedge clk_i) disable iff (!reset_n_i || out_clr_i)
        (tdp && rd[1] && wr_b && !wr_a && ctrl_reg.same_new && !ctrl_reg.out_reg) |=>
        rdata_b_o == $past(lane_get(wdata_b_i, ctrl_reg.wid_b, 2'b00));
    endproperty
    a_new: assert property (p_new) else $error("new data not shown");

    property p_group;
        @(posedge clk_i) disable iff (!reset_n_i)
        (sdp && grp_a != grp_b) |-> (!wr_a && !rd[1]);
    endproperty
    a_group: assert property (p_group) else $error("illegal width pair accepted");

    property p_tdp_cap;
        @(posedge clk_i) disable iff (!reset_n_i)
        (tdp && ctrl_reg.small_blk && ctrl_reg.wid_a == ram_pkg::W32) |-> (!wr_a && !wr_b);
    endproperty
    a_tdp_cap: assert property (p_tdp_cap) else $error("over-wide dual port accepted");

    property p_rom;
        @(posedge clk_i) disable iff (!reset_n_i)
        rom |-> !wr_a;
    endproperty
    a_rom: assert property (p_rom) else $error("rom written by fabric");

    property p_full;
        @(posedge clk_i) disable iff (!reset_n_i)
        (fifo && f_cnt_reg[8] && !rd[1] && !do_wr) |=> f_cnt_reg == $past(f_cnt_reg);
    endproperty
    a_full: assert property (p_full) else $error("push into full fifo");

    property p_clr;
        @(posedge clk_i) disable iff (!reset_n_i)
        out_clr_i |-> (rdata_a_o == '0 && rdata_b_o == '0);
    endproperty
    a_clr: assert property (p_clr) else $error("output clear ineffective");
endmodule
`default_nettype wire

// ---- rtl/ram_pkg.sv ----
`default_nettype none
package ram_pkg;
    // storage geometry
    localparam int DEPTH = 256;
    localparam int WAW = 8;
    localparam int PAW = 10;
    localparam int DW = 36;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MADDR = 8'h08;
    localparam logic [7:0] OFF_MDATA = 8'h0c;
    localparam logic [7:0] OFF_MPAR = 8'h10;
    localparam logic [7:0] OFF_SHIFT = 8'h14;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [23:0] SHIFT_RST = 24'h010101;
    // value shown for an undefined read result
    localparam logic [35:0] DC_FILL = 36'hfffffffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {MODE_SDP, MODE_TDP, MODE_SHIFT, MODE_ROM, MODE_FIFO} mode_t;
    typedef enum logic [1:0] {CLK_SINGLE, CLK_IO, CLK_RW, CLK_INDEP} clk_mode_t;
    typedef enum logic [2:0] {W8, W16, W32, W9, W18, W36} width_t;

    // control register layout, msb first
    typedef struct packed {
        logic lite;
        logic small_blk;
        logic out_reg;
        logic mixed_old;
        logic same_new;
        width_t wid_b;
        width_t wid_a;
        clk_mode_t clk_mode;
        mode_t mode;
    } ctrl_t;

    typedef struct packed {
        logic [7:0] tap_sel;
        logic [7:0] taps;
        logic [7:0] tap_len;
    } shift_t;

    typedef struct packed {
        logic [17:0] rsv;
        logic [8:0] fifo_cnt;
        logic [1:0] rsv2;
        logic full;
        logic empty;
        logic cfg_err;
    } status_t;
endpackage
`default_nettype wire

// ---- sim/fabric_model.sv ----
`default_nettype none
module fabric_model (
    input wire logic clk_i,
    output logic [3:0] en_o,
    output logic [9:0] addr_a_o,
    output logic [9:0] addr_b_o,
    output logic [35:0] wdata_a_o,
    output logic [35:0] wdata_b_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle fabric at time zero
    initial begin
        en_o = 4'h0;
        addr_a_o = 10'h000;
        addr_b_o = 10'h000;
        wdata_a_o = 36'h0;
        wdata_b_o = 36'h0;
    end
    // one cycle of port traffic, en = we_a, re_a, we_b, re_b
    task automatic op(input logic [3:0] en, input logic [9:0] aa, input logic [9:0] ab,
                      input logic [35:0] da, input logic [35:0] db);
        @(posedge clk_i);
        en_o <= en;
        addr_a_o <= aa;
        addr_b_o <= ab;
        wdata_a_o <= da;
        wdata_b_o <= db;
        @(posedge clk_i);
        en_o <= 4'h0;
        wdata_a_o <= ~da;
        wdata_b_o <= ~db;
    endtask
endmodule
`default_nettype wire

// ---- sim/dual_port_embedded_ram_bench.sv ----
`default_nettype none
module dual_port_embedded_ram_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clr = 1'b0;
    logic [3:0] en;
    logic [9:0] aa, ab;
    logic [35:0] da, db, qa, qb, so;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    int miscompares = 0;
    int comparisons = 0;
    // clock and partner
    always #2 clk_i = ~clk_i;
    fabric_model fab_u (.clk_i(clk_i), .en_o(en), .addr_a_o(aa), .addr_b_o(ab),
        .wdata_a_o(da), .wdata_b_o(db));
    ram_block dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .out_clr_i(clr),
        .ce_a_i(1'b1), .ce_b_i(1'b1), .ce_out_i(1'b1), .addr_a_i(aa), .wdata_a_i(da),
        .we_a_i(en[3]), .re_a_i(en[2]), .rdata_a_o(qa), .addr_b_i(ab), .wdata_b_i(db),
        .we_b_i(en[1]), .re_b_i(en[0]), .rdata_b_o(qb), .shift_out_o(so),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // register bus write and read
    task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_regs;
        axr(ram_pkg::OFF_SHIFT, d, r);
        chk("shift_rst", 36'(ram_pkg::SHIFT_RST), 36'(d));
        axr(8'h3c, d, r);
        chk("rresp_unmapped", 36'(ram_pkg::RESP_SLVERR), 36'(r));
        axw(8'h3c, 32'h1, r);
        chk("bresp_unmapped", 36'(ram_pkg::RESP_SLVERR), 36'(r));
        $display("t_regs done");
    endtask
    // write on A, read other word on B meanwhile
    task automatic t_sdp;
        axw(ram_pkg::OFF_CTRL, 32'h0240, r);
        fab_u.op(4'h8, 10'h005, 10'h000, 36'h012345678, 36'h0);
        fab_u.op(4'h9, 10'h006, 10'h005, 36'h0cafe0001, 36'h0);
        #1 chk("sdp_read", 36'h012345678, qb);
        $display("t_sdp done");
    endtask
    // same word collision, then enable low
    task automatic t_coll;
        fab_u.op(4'h9, 10'h005, 10'h005, 36'h0aaaa5555, 36'h0);
        #1 chk("coll_dc", ram_pkg::DC_FILL, qb);
        axw(ram_pkg::OFF_CTRL, 32'h1240, r);
        fab_u.op(4'h9, 10'h005, 10'h005, 36'h011112222, 36'h0);
        #1 chk("coll_old", 36'h0aaaa5555, qb);
        fab_u.op(4'h0, 10'h000, 10'h006, 36'h0, 36'h0);
        #1 chk("hold", 36'h0aaaa5555, qb);
        $display("t_coll done");
    endtask
    // output register adds one cycle
    task automatic t_oreg;
        axw(ram_pkg::OFF_CTRL, 32'h3240, r);
        fab_u.op(4'h1, 10'h000, 10'h006, 36'h0, 36'h0);
        #1 chk("oreg_early", 36'h0aaaa5555, qb);
        @(posedge clk_i);
        #1 chk("oreg_late", 36'h0cafe0001, qb);
        $display("t_oreg done");
    endtask
    // true dual-port: B writes with new data shown, A reads
    task automatic t_tdp;
        axw(ram_pkg::OFF_CTRL, 32'h0a41, r);
        fab_u.op(4'h7, 10'h006, 10'h007, 36'h0, 36'h055aa33cc);
        #1 chk("tdp_new", 36'h055aa33cc, qb);
        chk("tdp_rd_a", 36'h0cafe0001, qa);
        fab_u.op(4'h4, 10'h007, 10'h000, 36'h0, 36'h0);
        #1 chk("tdp_b_wr", 36'h055aa33cc, qa);
        $display("t_tdp done");
    endtask
    // asynchronous clear of both read outputs
    task automatic t_clr;
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        #1 chk("clr_a", 36'h0, qa);
        chk("clr_b", 36'h0, qb);
        $display("t_clr done");
    endtask
    // one-word shift chain, slot preloaded over the bus
    task automatic t_shift;
        axw(ram_pkg::OFF_MDATA, 32'h000000c3, r);
        axw(ram_pkg::OFF_CTRL, 32'h0002, r);
        fab_u.op(4'h8, 10'h000, 10'h000, 36'h9000000a1, 36'h0);
        #1 chk("shift_first", 36'h0000000c3, qb);
        fab_u.op(4'h8, 10'h000, 10'h000, 36'h0000000b2, 36'h0);
        #1 chk("shift_tap", 36'h9000000a1, qb);
        chk("shift_out", 36'h9000000a1, so);
        $display("t_shift done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_regs;
        t_sdp;
        t_coll;
        t_oreg;
        t_tdp;
        t_clr;
        t_shift;
        wrap_up;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        wrap_up;
    end
endmodule
`default_nettype wire
